/* src/dac_output_cal_commands.sv */
// command interpreter for output and calibration commands, apb slave
`include "dac_cmd_regs.svh"

module dac_output_cal_commands (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output      logic [31:0]               prdata_o,
  output      logic                      pready_o,
  output      logic                      pslverr_o,
  input  wire logic                      expanded_i,
  input  wire logic [15:0]               prog_sel_jumper_i,
  input  wire logic [15:0]               kind_current_jumper_i,
  input  wire logic                      store_en_jumper_i,
  input  wire logic                      trig_i,
  output      logic                      trig_fire_o,
  output      logic                      four_wire_o,
  output      dac_cmd_pkg::chan_out_s [15:0] chan_o
);
  import dac_cmd_pkg::*;

  // ==========================================================
  // bus decode
  logic        acc;
  logic        wr_cmd;
  logic        wr_stat;
  logic        wr_ctrl;
  logic        wr_res;
  logic        mapped;
  cmd_op_e     op;
  level_kw_e   kw;
  logic [4:0]  chan_f;
  logic [15:0] lvl_f;

  assign acc     = ce_i && psel_i && penable_i;
  assign wr_cmd  = acc && pwrite_i && paddr_i == `OFS_CMD;
  assign wr_stat = acc && pwrite_i && paddr_i == `OFS_STATUS;
  assign wr_ctrl = acc && pwrite_i && paddr_i == `OFS_CTRL;
  assign wr_res  = acc && pwrite_i && paddr_i == `OFS_RES_VALUE;
  assign op      = cmd_op_e'(pwdata_i[`CMD_OP_LSB +: 4]);
  assign kw      = level_kw_e'(pwdata_i[`CMD_KW_LSB +: 2]);
  assign chan_f  = pwdata_i[`CMD_CHAN_LSB +: 5];
  assign lvl_f   = pwdata_i[`CMD_LEVEL_LSB +: 16];
  assign mapped  = paddr_i == `OFS_CMD || paddr_i == `OFS_STATUS ||
                   paddr_i == `OFS_COND01 || paddr_i == `OFS_COND23 ||
                   paddr_i == `OFS_CTRL || paddr_i == `OFS_RES_VALUE;
  // zero-wait slave: every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ==========================================================
  // state
  trig_state_e trig_st;
  logic        err;
  logic        route_shared;
  logic [15:0] result;
  logic [15:0] cond [4];
  logic [15:0] nvm_cond [4];
  logic [31:0] cal_res;
  logic [31:0] nvm_res;
  logic [15:0] chk;
  logic [15:0] nvm_chk;

  // ==========================================================
  // command checks
  logic [4:0]  n_chans;
  logic        idx_ok;
  logic [3:0]  idx;
  logic        kind_ok;
  logic        lvl_ok;
  logic        apply_op;
  logic        apply_go;
  logic        busy_refuse;
  logic [15:0] sum_now;
  logic [15:0] next_level;
  logic [15:0] test_bits;

  assign n_chans = expanded_i ? `CHANS_EXP : `CHANS_BASE;
  assign idx_ok  = chan_f <= n_chans;
  assign idx     = (chan_f == 5'd0) ? 4'd0 : 4'(chan_f - 5'd1);
  assign apply_op = op == OP_APPLY_CUR || op == OP_APPLY_VLT;

  always_comb begin
    kind_ok = 1'b0;
    if (prog_sel_jumper_i[idx]) begin
      kind_ok = 1'b1;
    end else if (op == OP_APPLY_CUR) begin
      kind_ok = kind_current_jumper_i[idx];
    end else begin
      kind_ok = !kind_current_jumper_i[idx];
    end
  end

  // keyword to level, full scale is +-0.02 A or +-16 V
  always_comb begin
    next_level = lvl_f;
    unique case (kw)
      KW_VALUE: next_level = lvl_f;
      KW_MIN:   next_level = `LEVEL_NEG;
      KW_MAX:   next_level = `LEVEL_POS;
      KW_DEFAULT: next_level = `LEVEL_ZERO;
    endcase
  end
  assign lvl_ok   = !(kw == KW_VALUE && lvl_f == `LEVEL_ILLEGAL);
  assign apply_go = wr_cmd && apply_op && idx_ok && kind_ok && lvl_ok;

  // reload and check are refused while a trigger is awaited
  assign busy_refuse = trig_st == TRIG_WAIT &&
                       (op == OP_CAL_RLD || op == OP_CAL_TEST);

  assign sum_now = 16'(cond[0] + cond[1] + cond[2] + cond[3] +
                       cal_res[15:0] + cal_res[31:16]);

  // channel flagged if not calibrated for its present kind
  always_comb begin
    test_bits = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(n_chans)) begin
        test_bits[i] = chan_o[i].current_mode ? !cond[2][i] : !cond[3][i];
      end
    end
  end

  // ==========================================================
  // trigger system
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      trig_st     <= TRIG_IDLE;
      trig_fire_o <= 1'b0;
    end else if (ce_i) begin
      trig_fire_o <= 1'b0;
      if (wr_cmd && op == OP_ABORT) begin
        trig_st <= TRIG_IDLE;
      end else if (wr_cmd && op == OP_INIT) begin
        trig_st <= TRIG_WAIT;
      end else if (trig_st == TRIG_WAIT && trig_i) begin
        trig_st     <= TRIG_IDLE;
        trig_fire_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // channel outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 16; i++) begin
        // reset kind from jumpers, zero, relay open
        chan_o[i].relay        <= 1'b0;
        chan_o[i].level        <= `LEVEL_ZERO;
        chan_o[i].current_mode <= !prog_sel_jumper_i[i] &&
                                  kind_current_jumper_i[i];
      end
    end else if (ce_i && wr_cmd) begin
      if (apply_go) begin
        chan_o[idx].current_mode <= op == OP_APPLY_CUR;
        chan_o[idx].level        <= next_level;
        chan_o[idx].relay        <= 1'b1;
      end else if (op == OP_CAL_RLD && !busy_refuse) begin
        for (int i = 0; i < 16; i++) begin
          chan_o[i].relay <= 1'b0;
        end
      end else if (op == OP_CAL_TEST && !busy_refuse) begin
        // check leaves outputs off at zero
        for (int i = 0; i < 16; i++) begin
          chan_o[i].relay <= 1'b0;
          chan_o[i].level <= `LEVEL_ZERO;
        end
      end
    end
  end

  // ==========================================================
  // working and stored constants
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cond    <= '{`EXP_ABSENT, 16'h0000, 16'h0000, 16'h0000};
      cal_res <= `RES_DEFAULT;
      chk     <= `CHK_DEFAULT;
    end else if (ce_i) begin
      if (wr_cmd && op == OP_CAL_RLD && !busy_refuse) begin
        // copy stored set, as at power-on
        cond    <= nvm_cond;
        cal_res <= nvm_res;
        chk     <= nvm_chk;
      end else if (wr_res && pwdata_i != 32'h0000_0000) begin
        // new resistor value in use at once
        cal_res <= pwdata_i;
        chk     <= 16'(cond[0] + cond[1] + cond[2] + cond[3] +
                       pwdata_i[15:0] + pwdata_i[31:16]);
      end
    end
  end

  // reset stands in for the power-on contents of the stored set
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      nvm_cond <= '{`EXP_ABSENT, 16'h0000, 16'h0000, 16'h0000};
      nvm_res  <= `RES_DEFAULT;
      nvm_chk  <= `CHK_DEFAULT;
    end else if (ce_i && wr_cmd && op == OP_CAL_STORE) begin
      // written only with jumper and good checksum
      if (store_en_jumper_i && sum_now == chk) begin
        nvm_cond <= cond;
        nvm_res  <= cal_res;
        nvm_chk  <= chk;
      end
    end
  end

  // ==========================================================
  // query results, routing, error flag
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      result      <= 16'h0000;
      four_wire_o <= 1'b0;
    end else if (ce_i && wr_cmd) begin
      if (op == OP_RES_CFG) begin
        // ready unless a trigger is awaited
        result      <= {15'h0000, trig_st == TRIG_IDLE};
        four_wire_o <= route_shared;
      end else if (op == OP_CAL_TEST && !busy_refuse) begin
        result <= test_bits;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      route_shared <= `ROUTE_RESET;
    end else if (wr_ctrl) begin
      route_shared <= pwdata_i[`CTRL_ROUTE_BIT];
    end
  end

  logic err_set;
  always_comb begin
    err_set = 1'b0;
    if (wr_cmd) begin
      unique case (op)
        OP_APPLY_CUR, OP_APPLY_VLT: err_set = !apply_go;
        OP_CAL_RLD, OP_CAL_TEST:    err_set = busy_refuse;
        OP_CAL_STORE: err_set = !(store_en_jumper_i && sum_now == chk);
        OP_ABORT, OP_INIT, OP_RES_CFG, OP_NONE: err_set = 1'b0;
        default:                    err_set = 1'b1;
      endcase
    end else if (wr_res) begin
      err_set = pwdata_i == 32'h0000_0000;
    end
  end

  // set beats a clear arriving in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      err <= 1'b0;
    end else if (ce_i) begin
      err <= err_set || (err && !(wr_stat && pwdata_i[`STAT_ERR_BIT]));
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (psel_i && !pwrite_i) begin
      unique case (paddr_i)
        `OFS_STATUS: begin
          prdata_o[`STAT_WAIT_BIT]       = trig_st == TRIG_WAIT;
          prdata_o[`STAT_ERR_BIT]        = err;
          prdata_o[`STAT_FWIRE_BIT]      = four_wire_o;
          prdata_o[`STAT_RES_LSB +: 16]  = result;
        end
        `OFS_COND01:    prdata_o = {cond[1], cond[0]};
        `OFS_COND23:    prdata_o = {cond[3], cond[2]};
        `OFS_CTRL:      prdata_o[`CTRL_ROUTE_BIT] = route_shared;
        `OFS_RES_VALUE: prdata_o = cal_res;
        default:        prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd(cmd_op_e o);
    wr_cmd && op == o;
  endsequence

  property p_abort;
    s_cmd(OP_ABORT) |=> trig_st == TRIG_IDLE && !trig_fire_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not idle trigger");

  property p_init;
    s_cmd(OP_INIT) ##1 !wr_cmd[*2] |-> trig_st == TRIG_WAIT || trig_fire_o;
  endproperty
  a_init: assert property (p_init)
    else $error("initiate did not arm trigger");

  property p_bad_idx;
    wr_cmd && apply_op && chan_f > n_chans |=> err && $stable(chan_o);
  endproperty
  a_bad_idx: assert property (p_bad_idx)
    else $error("bad channel index not refused");

  property p_min_cur;
    apply_go && op == OP_APPLY_CUR && kw == KW_MIN
      |=> chan_o[$past(idx)].level == `LEVEL_NEG;
  endproperty
  a_min_cur: assert property (p_min_cur)
    else $error("min current keyword wrong");

  property p_max_vlt;
    apply_go && op == OP_APPLY_VLT && kw == KW_MAX
      |=> chan_o[$past(idx)].level == `LEVEL_POS;
  endproperty
  a_max_vlt: assert property (p_max_vlt)
    else $error("max voltage keyword wrong");

  property p_apply;
    apply_go |=> chan_o[$past(idx)].relay &&
      chan_o[$past(idx)].current_mode == ($past(op) == OP_APPLY_CUR);
  endproperty
  a_apply: assert property (p_apply)
    else $error("apply did not set kind and relay");

  property p_jumper_cur;
    wr_cmd && op == OP_APPLY_CUR && idx_ok && chan_f != 5'd0 &&
      !prog_sel_jumper_i[idx] && !kind_current_jumper_i[idx]
      |=> err && $stable(chan_o);
  endproperty
  a_jumper_cur: assert property (p_jumper_cur)
    else $error("current apply passed voltage jumper");

  property p_jumper_vlt;
    wr_cmd && op == OP_APPLY_VLT && idx_ok &&
      !prog_sel_jumper_i[idx] && kind_current_jumper_i[idx]
      |=> err && $stable(chan_o);
  endproperty
  a_jumper_vlt: assert property (p_jumper_vlt)
    else $error("voltage apply passed current jumper");

  property p_busy;
    wr_cmd && trig_st == TRIG_WAIT && op == OP_CAL_RLD
      |=> err && $stable(chan_o) && $stable(cal_res);
  endproperty
  a_busy: assert property (p_busy)
    else $error("reload accepted while waiting");

  property p_store;
    wr_cmd && op == OP_CAL_STORE && !store_en_jumper_i
      |=> $stable(nvm_res) && $stable(nvm_chk) && err;
  endproperty
  a_store: assert property (p_store)
    else $error("store ignored jumper");

  property p_test_off;
    wr_cmd && op == OP_CAL_TEST && !busy_refuse
      |=> chan_o[0].relay == 1'b0 && chan_o[0].level == `LEVEL_ZERO &&
          chan_o[15].relay == 1'b0 && result == $past(test_bits);
  endproperty
  a_test_off: assert property (p_test_off)
    else $error("check left outputs on");

  property p_res_zero;
    wr_res && pwdata_i == 32'h0000_0000 |=> $stable(cal_res) && err;
  endproperty
  a_res_zero: assert property (p_res_zero)
    else $error("zero resistor value accepted");
endmodule

/* src/dac_cmd_regs.svh */
// register offsets, field positions, codes and reset values
`ifndef DAC_CMD_REGS_SVH
`define DAC_CMD_REGS_SVH

`define OFS_CMD        12'h000
`define OFS_STATUS     12'h004
`define OFS_COND01     12'h008
`define OFS_COND23     12'h00c
`define OFS_CTRL       12'h010
`define OFS_RES_VALUE  12'h014

`define CMD_OP_LSB     0
`define CMD_KW_LSB     4
`define CMD_CHAN_LSB   8
`define CMD_LEVEL_LSB  16
`define STAT_WAIT_BIT  0
`define STAT_ERR_BIT   1
`define STAT_FWIRE_BIT 2
`define STAT_RES_LSB   16
`define CTRL_ROUTE_BIT 0

`define CHANS_BASE     5'd8
`define CHANS_EXP      5'd16

`define LEVEL_POS      16'h7fff
`define LEVEL_NEG      16'h8001
`define LEVEL_ZERO     16'h0000
`define LEVEL_ILLEGAL  16'h8000

`define EXP_PRESENT    16'h0000
`define EXP_ABSENT     16'h0007
`define RES_DEFAULT    32'h0000_00c8
`define CHK_DEFAULT    16'h00cf
`define ROUTE_RESET    1'b1
`endif

/* src/dac_cmd_pkg.sv */
// types shared by the command interpreter and its users
package dac_cmd_pkg;
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_ABORT     = 4'h1,
    OP_INIT      = 4'h2,
    OP_APPLY_CUR = 4'h3,
    OP_APPLY_VLT = 4'h4,
    OP_RES_CFG   = 4'h6,
    OP_CAL_RLD   = 4'h7,
    OP_CAL_STORE = 4'h8,
    OP_CAL_TEST  = 4'h9
  } cmd_op_e;

  typedef enum logic [1:0] {
    KW_VALUE   = 2'd0,
    KW_MIN     = 2'd1,
    KW_MAX     = 2'd2,
    KW_DEFAULT = 2'd3
  } level_kw_e;

  typedef enum logic {
    TRIG_IDLE,
    TRIG_WAIT
  } trig_state_e;

  // one analog channel as seen by the output stage
  typedef struct packed {
    logic        relay;
    logic        current_mode;
    logic [15:0] level;
  } chan_out_s;
endpackage

/* verification/host_apb_master.sv */
// apb host model that issues register and command transfers
module host_apb_master (
  input  wire logic        clk_i,
  output      logic        psel_o,
  output      logic        penable_o,
  output      logic        pwrite_o,
  output      logic [11:0] paddr_o,
  output      logic [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output      logic        hang_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0;
    hang_o    = 1'b0;
  end

  // ==========================================================
  // one transfer; called just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    int n;
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= addr;
    pwdata_o  <= wdata;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 32);
    if (pready_i !== 1'b1)
      hang_o <= 1'b1;
    rdata = prdata_i;
    err   = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // stale write data must not look valid once released
    pwdata_o  <= ~wdata;
    @(posedge clk_i);
  endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the output and calibration commands
`include "dac_cmd_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dac_cmd_pkg::*;

  logic             sys_clk;
  logic             rst_n;
  logic             ce;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             expanded;
  logic [15:0]      prog_sel;
  logic [15:0]      kind_cur;
  logic             store_en;
  logic             trig;
  logic             trig_fire;
  logic             four_wire;
  chan_out_s [15:0] chan;
  logic             hang;
  logic [31:0]      rdat;
  logic             rerr;
  int               bad_count;
  int               check_count;

  dac_output_cal_commands dac_output_cal_commands_inst (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .expanded_i(expanded),
    .prog_sel_jumper_i(prog_sel), .kind_current_jumper_i(kind_cur),
    .store_en_jumper_i(store_en), .trig_i(trig), .trig_fire_o(trig_fire),
    .four_wire_o(four_wire), .chan_o(chan));

  host_apb_master host_apb_master_inst (
    .clk_i(sys_clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr), .hang_o(hang));

  // ==========================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_apb_master_inst.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [11:0] a);
    host_apb_master_inst.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [1:0] kw,
                     input logic [4:0] ch, input logic [15:0] lv);
    wr(`OFS_CMD, {lv, 3'h0, ch, 2'h0, kw, op});
  endtask

  // reads the sticky error flag, then clears it for the next step
  task automatic err_is(input logic e);
    rd(`OFS_STATUS);
    check({31'h0, rdat[1]}, {31'h0, e});
    wr(`OFS_STATUS, 32'h2);
  endtask

  task automatic ch_is(input int i, input logic rel, input logic cur,
                       input logic [15:0] lv);
    check({14'h0, chan[i]}, {14'h0, rel, cur, lv});
  endtask

  task automatic fires(output logic [31:0] n);
    n = 0;
    trig <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk);
      #1 n += {31'h0, trig_fire === 1'b1};
    end
    @(posedge sys_clk);
    trig <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ==========================================================
  // scenarios
  // reset state
  task automatic t_reset;
    logic [11:0] a[5] = '{`OFS_STATUS, `OFS_COND01, `OFS_COND23,
                          `OFS_CTRL, `OFS_RES_VALUE};
    logic [31:0] e[5] = '{32'h0, 32'h7, 32'h0, 32'h1, `RES_DEFAULT};
    for (int i = 0; i < 16; i++)
      ch_is(i, 1'b0, ~prog_sel[i] & kind_cur[i], 16'h0);
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      check(rdat, e[i]);
    end
    rd(12'h018);
    check({rerr, rdat[30:0]}, 32'h8000_0000);
    $display("t_reset done");
  endtask

  task automatic t_apply;
    logic [15:0] lv[4] = '{16'h1234, `LEVEL_NEG, `LEVEL_POS, `LEVEL_ZERO};
    for (int k = 0; k < 4; k++) begin
      cmd(OP_APPLY_VLT, k[1:0], 5'd3, 16'h1234);
      ch_is(2, 1'b1, 1'b0, lv[k]);
      cmd(OP_APPLY_CUR, k[1:0], 5'd0, 16'h1234);
      ch_is(0, 1'b1, 1'b1, lv[k]);
    end
    err_is(1'b0);
    cmd(OP_APPLY_VLT, KW_VALUE, 5'd9, 16'h0100);
    err_is(1'b1);
    cmd(OP_APPLY_CUR, KW_VALUE, 5'd1, `LEVEL_ILLEGAL);
    err_is(1'b1);
    ch_is(0, 1'b1, 1'b1, `LEVEL_ZERO);
    expanded <= 1'b1;
    cmd(OP_APPLY_CUR, KW_VALUE, 5'd16, 16'h0100);
    err_is(1'b0);
    ch_is(15, 1'b1, 1'b1, 16'h0100);
    cmd(OP_APPLY_CUR, KW_VALUE, 5'd17, 16'h0100);
    err_is(1'b1);
    $display("t_apply done");
  endtask

  task automatic t_jumper;
    cmd(OP_APPLY_CUR, KW_VALUE, 5'd9, 16'h0200);
    err_is(1'b1);
    ch_is(8, 1'b0, 1'b0, 16'h0);
    cmd(OP_APPLY_VLT, KW_VALUE, 5'd9, 16'h0200);
    err_is(1'b0);
    ch_is(8, 1'b1, 1'b0, 16'h0200);
    cmd(OP_APPLY_VLT, KW_VALUE, 5'd13, 16'h0200);
    err_is(1'b1);
    $display("t_jumper done");
  endtask

  task automatic t_trig;
    logic [31:0] n;
    cmd(OP_INIT, KW_VALUE, 5'd0, 16'h0);
    rd(`OFS_STATUS);
    check({31'h0, rdat[0]}, 32'h1);
    cmd(OP_CAL_RLD, KW_VALUE, 5'd0, 16'h0);
    err_is(1'b1);
    ch_is(2, 1'b1, 1'b0, `LEVEL_ZERO);
    cmd(OP_CAL_TEST, KW_VALUE, 5'd0, 16'h0);
    err_is(1'b1);
    cmd(OP_ABORT, KW_VALUE, 5'd0, 16'h0);
    fires(n);
    check(n, 32'h0);
    cmd(OP_INIT, KW_VALUE, 5'd0, 16'h0);
    fires(n);
    check(n, 32'h1);
    rd(`OFS_STATUS);
    check({31'h0, rdat[0]}, 32'h0);
    $display("t_trig done");
  endtask

  task automatic t_cal;
    cmd(OP_RES_CFG, KW_VALUE, 5'd0, 16'h0);
    rd(`OFS_STATUS);
    check({16'h0, rdat[31:16]}, 32'h1);
    check({31'h0, four_wire}, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    cmd(OP_RES_CFG, KW_VALUE, 5'd0, 16'h0);
    check({31'h0, four_wire}, 32'h0);
    wr(`OFS_RES_VALUE, 32'h0);
    err_is(1'b1);
    // host side supplies a positive resistor value
    wr(`OFS_RES_VALUE, 32'h64);
    rd(`OFS_RES_VALUE);
    check(rdat, 32'h64);
    cmd(OP_CAL_STORE, KW_VALUE, 5'd0, 16'h0);
    err_is(1'b1);
    cmd(OP_CAL_RLD, KW_VALUE, 5'd0, 16'h0);
    rd(`OFS_RES_VALUE);
    check(rdat, `RES_DEFAULT);
    for (int i = 0; i < 16; i++)
      check({31'h0, chan[i].relay}, 32'h0);
    wr(`OFS_RES_VALUE, 32'h64);
    store_en <= 1'b1;
    cmd(OP_CAL_STORE, KW_VALUE, 5'd0, 16'h0);
    err_is(1'b0);
    wr(`OFS_RES_VALUE, 32'h32);
    cmd(OP_CAL_RLD, KW_VALUE, 5'd0, 16'h0);
    rd(`OFS_RES_VALUE);
    check(rdat, 32'h64);
    cmd(OP_APPLY_CUR, KW_MAX, 5'd1, 16'h0);
    cmd(OP_APPLY_VLT, KW_MIN, 5'd3, 16'h0);
    cmd(OP_CAL_TEST, KW_VALUE, 5'd0, 16'h0);
    rd(`OFS_STATUS);
    check({16'h0, rdat[31:16]}, 32'hffff);
    ch_is(0, 1'b0, 1'b1, 16'h0);
    ch_is(2, 1'b0, 1'b0, 16'h0);
    // frozen clock enable must drop the command
    ce <= 1'b0;
    cmd(OP_APPLY_VLT, KW_MAX, 5'd1, 16'h0);
    ce <= 1'b1;
    ch_is(0, 1'b0, 1'b1, 16'h0);
    $display("t_cal done");
  endtask

  // ==========================================================
  // clock, reset, sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge hang) begin
    bad_count++;
    test_done;
  end

  initial begin
    bad_count   = 0;
    check_count = 0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    expanded    = 1'b0;
    prog_sel    = 16'h00ff;
    kind_cur    = 16'hf0f0;
    store_en    = 1'b0;
    trig        = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_apply;
    t_jumper;
    t_trig;
    t_cal;
    test_done;
  end
endmodule
